/* File: hw/dtov_overvoltage.sv */
// Three-channel definite-time overvoltage logic with settings registers.
// Assumes magnitudes and block input come from logic on ref_clk, and a
// register master that never overlaps read and write strobes.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ns

module dtov_overvoltage #(
  parameter int CYCLES_PER_MS = dtov_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Register port
  input  wire logic [dtov_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [dtov_pkg::DATA_W-1:0] regWrData,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [dtov_pkg::DATA_W-1:0] regRdData,
  // Measured channel magnitudes
  input  wire logic [dtov_pkg::MAG_W-1:0]  chanAMagnitude,
  input  wire logic [dtov_pkg::MAG_W-1:0]  chanBMagnitude,
  input  wire logic [dtov_pkg::MAG_W-1:0]  chanCMagnitude,
  // User blocking
  input  wire logic                       userBlockInput,
  // Published status
  output logic      [dtov_pkg::NCHAN-1:0]  chanStart,
  output logic                            generalStartOut,
  output logic                            generalTripOut,
  output logic                            chanPairMode
);

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  logic        operOn;
  logic        startOnly;
  logic [7:0]  startLevel;
  logic [3:0]  hystPct;
  logic [15:0] tripDelayMs;
  logic [15:0] elapsedMs;
  logic        funcEnable;
  logic        msTick;
  logic [31:0] prescale;
  logic [dtov_pkg::NCHAN-1:0] nextStart;
  logic [dtov_pkg::MAG_W-1:0] startThr;
  logic [dtov_pkg::MAG_W-1:0] dropThr;
  logic [dtov_pkg::MAG_W-1:0] chanMag [dtov_pkg::NCHAN];
  logic [7:0]  wrLevel;
  logic [3:0]  wrHyst;

  assign wrLevel = regWrData[7:0];
  assign wrHyst  = regWrData[3:0];

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      operOn       <= dtov_pkg::OPER_DEF;
      startOnly    <= dtov_pkg::SONLY_DEF;
      chanPairMode <= dtov_pkg::PAIR_DEF;
    end
    else if (regWr && regAddr == dtov_pkg::REG_CTRL)
    begin
      operOn       <= regWrData[dtov_pkg::CTRL_OPER_BIT];
      startOnly    <= regWrData[dtov_pkg::CTRL_SONLY_BIT];
      chanPairMode <= regWrData[dtov_pkg::CTRL_PAIR_BIT];
    end
  end

  // Out-of-range writes are clamped so the comparators never see
  // a level outside the settable band.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      startLevel <= dtov_pkg::LEVEL_DEF;
    else if (regWr && regAddr == dtov_pkg::REG_LEVEL)
    begin
      if (regWrData[15:8] != 8'h00 || wrLevel > dtov_pkg::LEVEL_MAX)
        startLevel <= dtov_pkg::LEVEL_MAX;
      else if (wrLevel < dtov_pkg::LEVEL_MIN)
        startLevel <= dtov_pkg::LEVEL_MIN;
      else
        startLevel <= wrLevel;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      hystPct <= dtov_pkg::HYST_DEF;
    else if (regWr && regAddr == dtov_pkg::REG_HYST)
    begin
      if (regWrData[15:4] != 12'h000 || wrHyst > dtov_pkg::HYST_MAX)
        hystPct <= dtov_pkg::HYST_MAX;
      else if (wrHyst < dtov_pkg::HYST_MIN)
        hystPct <= dtov_pkg::HYST_MIN;
      else
        hystPct <= wrHyst;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      tripDelayMs <= dtov_pkg::DELAY_DEF;
    else if (regWr && regAddr == dtov_pkg::REG_DELAY)
    begin
      if (regWrData > dtov_pkg::DELAY_MAX)
        tripDelayMs <= dtov_pkg::DELAY_MAX;
      else
        tripDelayMs <= regWrData;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stand only in the cycle after the strobe; zero otherwise and
  // for unmapped addresses.
  always_ff @(posedge ref_clk)
  begin
    if (rst || !regRd)
      regRdData <= 16'h0000;
    else
    begin
      case (regAddr)
        dtov_pkg::REG_CTRL:
          regRdData <= {13'h0000, chanPairMode, startOnly, operOn};
        dtov_pkg::REG_LEVEL:
          regRdData <= {8'h00, startLevel};
        dtov_pkg::REG_HYST:
          regRdData <= {12'h000, hystPct};
        dtov_pkg::REG_DELAY:
          regRdData <= tripDelayMs;
        dtov_pkg::REG_STATUS:
          regRdData <= {10'h000, userBlockInput, generalTripOut,
                        generalStartOut, chanStart};
        dtov_pkg::REG_TIMER:
          regRdData <= elapsedMs;
        default:
          regRdData <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Enable and thresholds
  // ----------------------------------------------------------------
  assign funcEnable = operOn && !userBlockInput;

  // Magnitudes are in hundredths of a percent, so the level times the
  // scale is exact and the drop level keeps integer hysteresis.
  assign startThr = 16'(startLevel) * dtov_pkg::PCT_SCALE;
  assign dropThr  = 16'(startLevel)
                  * (dtov_pkg::PCT_FULL - 16'(hystPct));

  assign chanMag[0] = chanAMagnitude;
  assign chanMag[1] = chanBMagnitude;
  assign chanMag[2] = chanCMagnitude;

  // ----------------------------------------------------------------
  // Channel detectors
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < dtov_pkg::NCHAN; ch++)
  begin : gChan
    dtov_chan_start uStart (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .enable       (funcEnable),
      .startThr     (startThr),
      .dropThr      (dropThr),
      .magnitude    (chanMag[ch]),
      .next_started (nextStart[ch]),
      .started      (chanStart[ch])
    );
  end

  // General start taken from the same next values keeps it aligned
  // with the channel flags in every cycle.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      generalStartOut <= 1'b0;
    else
      generalStartOut <= funcEnable && (|nextStart);
  end

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  // Restarted with every new start so the first millisecond is whole.
  always_ff @(posedge ref_clk)
  begin
    if (rst || !generalStartOut)
      prescale <= 32'h0000_0000;
    else if (msTick)
      prescale <= 32'h0000_0000;
    else
      prescale <= prescale + 32'h0000_0001;
  end

  assign msTick = (prescale == 32'(CYCLES_PER_MS - 1));

  // ----------------------------------------------------------------
  // Delay timer and trip
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst || !funcEnable || !generalStartOut)
      elapsedMs <= 16'h0000;
    else if (msTick && elapsedMs < tripDelayMs)
      elapsedMs <= elapsedMs + 16'h0001;
  end

  // Per-channel trips are never formed; only the general trip leaves.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      generalTripOut <= 1'b0;
    else
      generalTripOut <= funcEnable && generalStartOut
                     && !startOnly
                     && elapsedMs >= tripDelayMs;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence sStartHeld;
    funcEnable && generalStartOut && !startOnly;
  endsequence

  sequence sDelayDone;
    sStartHeld ##0 elapsedMs >= tripDelayMs;
  endsequence

  AST_GEN_START: assert property (
    generalStartOut == (|chanStart))
    else $error("General start differs from channel starts");

  AST_START_ONLY: assert property (
    $past(startOnly) |-> !generalTripOut)
    else $error("Trip seen in start-only mode");

  AST_OFF_CLEARS: assert property (
    !funcEnable |=> !generalStartOut && !generalTripOut
                    && chanStart == 3'b000 && elapsedMs == 16'h0000)
    else $error("Outputs not cleared when disabled");

  AST_TRIP_CAUSE: assert property (
    generalTripOut |-> $past(elapsedMs) >= $past(tripDelayMs)
                       && $past(generalStartOut))
    else $error("Trip before delay expired");

  AST_TIMER_CLEAR: assert property (
    !generalStartOut |=> elapsedMs == 16'h0000)
    else $error("Timer not cleared after start dropped");

  AST_TIMER_STEP: assert property (
    funcEnable && generalStartOut && msTick && elapsedMs < tripDelayMs
    |=> elapsedMs == $past(elapsedMs) + 16'h0001)
    else $error("Timer did not advance on tick");

  AST_TRIP_ON_TIME: assert property (
    sDelayDone ##1 sStartHeld |-> generalTripOut)
    else $error("Trip missing after delay");

  AST_SETTING_RANGE: assert property (
    tripDelayMs <= dtov_pkg::DELAY_MAX
    && startLevel >= dtov_pkg::LEVEL_MIN
    && startLevel <= dtov_pkg::LEVEL_MAX)
    else $error("Setting outside its range");

  AST_OPER_OFF: assert property (
    !operOn ##1 !operOn |-> !generalStartOut && !generalTripOut)
    else $error("Function active while switched off");

  // ----------------------------------------------------------------
  // Pickup and timer phases
  // ----------------------------------------------------------------
  // Quiet means nothing started and no channel above the level, so a
  // magnitude sitting exactly on the level must not pick up.
  sequence sAnyAbove;
    chanMag[0] > startThr || chanMag[1] > startThr
    || chanMag[2] > startThr;
  endsequence

  sequence sAllQuiet;
    chanMag[0] <= startThr && chanMag[1] <= startThr
    && chanMag[2] <= startThr && chanStart == 3'b000;
  endsequence

  sequence sFreshStart;
    !generalStartOut ##1 generalStartOut;
  endsequence

  AST_GEN_PICKUP: assert property (
    funcEnable ##0 sAnyAbove |=> generalStartOut)
    else $error("General start missing above level");

  AST_NO_PICKUP: assert property (
    funcEnable ##0 sAllQuiet |=> !generalStartOut)
    else $error("General start raised at or below level");

  AST_TIMER_FRESH: assert property (
    sFreshStart |-> elapsedMs == 16'h0000 && prescale == 32'h0000_0000)
    else $error("New start did not begin a full delay");

  AST_TIMER_HOLD: assert property (
    funcEnable && generalStartOut && !msTick
    |=> elapsedMs == $past(elapsedMs))
    else $error("Timer moved between ticks");

  AST_BLOCK_CLEARS: assert property (
    userBlockInput |=> chanStart == 3'b000 && !generalTripOut)
    else $error("Outputs not cleared while blocked");

  // A delay rewrite may legally push the expiry out again
  AST_TRIP_STANDS: assert property (
    generalTripOut && funcEnable && generalStartOut && !startOnly
    && $stable(tripDelayMs) |=> generalTripOut)
    else $error("Trip fell while start held");

endmodule : dtov_overvoltage

/* File: hw/dtov_pkg.sv */
// Package for the definite-time overvoltage block: register map,
// field positions, reset values, setting ranges and timing constants.
// Assumes one 125 MHz clock and magnitudes in 0.01 % of nominal.

package dtov_pkg;

  // ----------------------------------------------------------------
  // Bus and data widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int MAG_W  = 16;
  localparam int NCHAN  = 3;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_LEVEL  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_HYST   = 4'h2;
  localparam logic [ADDR_W-1:0] REG_DELAY  = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_TIMER  = 4'h5;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_OPER_BIT  = 0;
  localparam int CTRL_SONLY_BIT = 1;
  localparam int CTRL_PAIR_BIT  = 2;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int STAT_GST_BIT = 3;
  localparam int STAT_GTR_BIT = 4;
  localparam int STAT_BLK_BIT = 5;

  // ----------------------------------------------------------------
  // Setting ranges and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  LEVEL_MIN = 8'h1E;
  localparam logic [7:0]  LEVEL_MAX = 8'h82;
  localparam logic [7:0]  LEVEL_DEF = 8'h6E;
  localparam logic [3:0]  HYST_MIN  = 4'h1;
  localparam logic [3:0]  HYST_MAX  = 4'hA;
  localparam logic [3:0]  HYST_DEF  = 4'h5;
  localparam logic [15:0] DELAY_MAX = 16'hEA60;
  localparam logic [15:0] DELAY_DEF = 16'h0064;
  localparam logic        OPER_DEF  = 1'b0;
  localparam logic        SONLY_DEF = 1'b0;
  localparam logic        PAIR_DEF  = 1'b1;

  // Magnitude units per percent, and the whole of nominal in percent
  localparam logic [15:0] PCT_SCALE = 16'h0064;
  localparam logic [15:0] PCT_FULL  = 16'h0064;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

endpackage : dtov_pkg

/* File: hw/dtov_chan_start.sv */
// One channel start detector with drop-off hysteresis.
// Assumes thresholds and enable come from logic on the same clock.
`timescale 1ns/1ns

module dtov_chan_start (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // Control
  input  wire logic                      enable,
  input  wire logic [dtov_pkg::MAG_W-1:0] startThr,
  input  wire logic [dtov_pkg::MAG_W-1:0] dropThr,
  // Measurement and result
  input  wire logic [dtov_pkg::MAG_W-1:0] magnitude,
  output logic                           next_started,
  output logic                           started
);

  always_comb
  begin
    next_started = started;
    if (!enable)
      next_started = 1'b0;
    else if (!started && magnitude > startThr)
      next_started = 1'b1;
    else if (started && magnitude <= dropThr)
      next_started = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      started <= 1'b0;
    else
      started <= next_started;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_CHAN_PICKUP: assert property (@(posedge ref_clk) disable iff (rst)
    enable && magnitude > startThr |=> started)
    else $error("Channel did not start above level");

  AST_CHAN_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    enable && started && magnitude > dropThr |=> started)
    else $error("Channel dropped inside hysteresis band");

endmodule : dtov_chan_start

/* File: tb/dtov_mag_source.sv */
// Model of the upstream magnitude stage and the user blocking logic.
// Assumes the block samples these levels on rising edges of ref_clk.
`timescale 1ns/1ns

module dtov_mag_source (
  // Clock
  input  wire logic                        ref_clk,
  // Toward the block
  output logic      [dtov_pkg::MAG_W-1:0]  chanAMagnitude,
  output logic      [dtov_pkg::MAG_W-1:0]  chanBMagnitude,
  output logic      [dtov_pkg::MAG_W-1:0]  chanCMagnitude,
  output logic                             userBlockInput
);
  initial
  begin
    chanAMagnitude = 16'h0000;
    chanBMagnitude = 16'h0000;
    chanCMagnitude = 16'h0000;
    userBlockInput = 1'b0;
  end

  // Levels change just after an edge, like a real upstream stage
  task automatic drive(input logic [15:0] a, input logic [15:0] b,
                       input logic [15:0] c, input logic blk);
    @(posedge ref_clk);
    chanAMagnitude <= a;
    chanBMagnitude <= b;
    chanCMagnitude <= c;
    userBlockInput <= blk;
  endtask : drive
endmodule : dtov_mag_source

/* File: tb/tb_top.sv */
// Self-checking bench for the overvoltage block.
// Assumes a 1 ms tick shortened to 4 clocks.
`timescale 1ns/1ns

module tb_top;
  localparam int CPM = 4;
  logic        ref_clk;
  logic        rst;
  logic [3:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdData;
  logic [15:0] magA;
  logic [15:0] magB;
  logic [15:0] magC;
  logic        blk;
  logic [2:0]  chanStart;
  logic        gst;
  logic        gtr;
  logic        pair;
  int          errors;
  int          checksDone;

  dtov_mag_source i_src (.ref_clk(ref_clk), .chanAMagnitude(magA),
    .chanBMagnitude(magB), .chanCMagnitude(magC), .userBlockInput(blk));

  dtov_overvoltage #(.CYCLES_PER_MS(CPM)) i_dut (.ref_clk(ref_clk),
    .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .chanAMagnitude(magA),
    .chanBMagnitude(magB), .chanCMagnitude(magC), .userBlockInput(blk),
    .chanStart(chanStart), .generalStartOut(gst), .generalTripOut(gtr),
    .chanPairMode(pair));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [15:0] s,
                       input logic [15:0] e);
    checksDone++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdChk(input string n, input logic [3:0] a,
                       input logic [15:0] e);
    @(posedge ref_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    check(n, regRdData, e);
  endtask : rdChk

  task automatic outs(input logic [2:0] s, input logic g, input logic t);
    check("chanStart", {13'h0000, chanStart}, {13'h0000, s});
    check("genStart", {15'h0000, gst}, {15'h0000, g});
    check("genTrip", {15'h0000, gtr}, {15'h0000, t});
  endtask : outs

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testReset;
    rdChk("ctrl", 4'h0, 16'h0004);
    rdChk("level", 4'h1, 16'h006E);
    rdChk("hyst", 4'h2, 16'h0005);
    rdChk("delay", 4'h3, 16'h0064);
    rdChk("unmapped", 4'hF, 16'h0000);
    check("pair", {15'h0000, pair}, 16'h0001);
    i_src.drive(16'h3000, 16'h3000, 16'h3000, 1'b0);
    tick(3);
    outs(3'b000, 1'b0, 1'b0);
    i_src.drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
    $display("test reset done");
  endtask : testReset

  task automatic testChannels;
    logic [15:0] m [3];
    wr(4'h0, 16'h0005);
    wr(4'h3, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      m = '{16'h0000, 16'h0000, 16'h0000};
      m[i] = 16'd11000;
      i_src.drive(m[0], m[1], m[2], 1'b0);
      tick(2);
      outs(3'b000, 1'b0, 1'b0);
      m[i] = 16'd11001;
      i_src.drive(m[0], m[1], m[2], 1'b0);
      tick(1);
      outs(3'b001 << i, 1'b1, 1'b0);
      tick(1);
      outs(3'b001 << i, 1'b1, 1'b1);
      i_src.drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
      tick(2);
      outs(3'b000, 1'b0, 1'b0);
    end
    $display("test channels done");
  endtask : testChannels

  task automatic testHyst;
    i_src.drive(16'd11001, 16'h0000, 16'h0000, 1'b0);
    i_src.drive(16'd10451, 16'h0000, 16'h0000, 1'b0);
    tick(3);
    outs(3'b001, 1'b1, 1'b1);
    i_src.drive(16'd10450, 16'h0000, 16'h0000, 1'b0);
    tick(1);
    outs(3'b000, 1'b0, 1'b1);
    tick(1);
    outs(3'b000, 1'b0, 1'b0);
    $display("test hysteresis done");
  endtask : testHyst

  // Trip rises 3 ms of ticks plus one cycle after the start
  task automatic delayRun(input logic b);
    i_src.drive(16'd12000, 16'h0000, 16'h0000, b);
    tick(1);
    outs(3'b001, 1'b1, 1'b0);
    tick(3 * CPM);
    outs(3'b001, 1'b1, 1'b0);
    tick(1);
    outs(3'b001, 1'b1, 1'b1);
  endtask : delayRun

  task automatic testDelay;
    wr(4'h3, 16'h0003);
    delayRun(1'b0);
    i_src.drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
    tick(2);
    outs(3'b000, 1'b0, 1'b0);
    rdChk("timerDrop", 4'h5, 16'h0000);
    delayRun(1'b0);
    i_src.drive(16'd12000, 16'h0000, 16'h0000, 1'b1);
    tick(1);
    outs(3'b000, 1'b0, 1'b0);
    rdChk("timer", 4'h5, 16'h0000);
    rdChk("statusBlk", 4'h4, 16'h0020);
    delayRun(1'b0);
    $display("test delay done");
  endtask : testDelay

  task automatic testStartOnly;
    wr(4'h0, 16'h0007);
    tick(20);
    outs(3'b001, 1'b1, 1'b0);
    wr(4'h0, 16'h0005);
    tick(3);
    outs(3'b001, 1'b1, 1'b1);
    rdChk("statusTrip", 4'h4, 16'h0019);
    rdChk("timerSat", 4'h5, 16'h0003);
    wr(4'h0, 16'h0004);
    tick(1);
    outs(3'b000, 1'b0, 1'b0);
    i_src.drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
    $display("test start only done");
  endtask : testStartOnly

  task automatic testClamp;
    logic [3:0]  a [7] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5};
    logic [15:0] w [7] = '{16'h00FF, 16'h0000, 16'h0000, 16'h00FF,
                           16'hFFFF, 16'hFFFF, 16'hFFFF};
    logic [15:0] e [7] = '{16'h0082, 16'h001E, 16'h0001, 16'h000A,
                           16'hEA60, 16'h0000, 16'h0000};
    for (int i = 0; i < 7; i++)
    begin
      wr(a[i], w[i]);
      rdChk("clamp", a[i], e[i]);
    end
    wr(4'h0, 16'h0000);
    rdChk("ctrlPair", 4'h0, 16'h0000);
    check("pairOff", {15'h0000, pair}, 16'h0000);
    $display("test clamp done");
  endtask : testClamp

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : printVerdict

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial
  begin
    #(20000 * 8);
    errors++;
    printVerdict();
  end

  initial
  begin
    errors     = 0;
    checksDone = 0;
    rst        = 1'b1;
    regAddr    = 4'h0;
    regWrData  = 16'h0000;
    regWr      = 1'b0;
    regRd      = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    testReset();
    testChannels();
    testHyst();
    testDelay();
    testStartOnly();
    testClamp();
    printVerdict();
  end
endmodule : tb_top
